//--- verilog/pfsc_pkg.sv
package pfsc_pkg;

   // register indices; byte address is four times the index
   localparam int NREG = 13;
   localparam logic [9:0] IDX_B_MODE = 10'h088;
   localparam logic [9:0] IDX_B_FRAC_HI = 10'h089;
   localparam logic [9:0] IDX_B_FRAC_MID = 10'h08a;
   localparam logic [9:0] IDX_B_FRAC_LO = 10'h08b;
   localparam logic [9:0] IDX_C_MODE = 10'h08c;
   localparam logic [9:0] IDX_C_FRAC_HI = 10'h08d;
   localparam logic [9:0] IDX_C_FRAC_MID = 10'h08e;
   localparam logic [9:0] IDX_C_FRAC_LO = 10'h08f;
   localparam logic [9:0] IDX_SEQ_CTRL = 10'h096;
   localparam logic [9:0] IDX_LOOP_CTRL1 = 10'h09b;
   localparam logic [9:0] IDX_LOOP_DIV = 10'h09c;
   localparam logic [9:0] IDX_LOOP_FRATIO = 10'h09d;
   localparam logic [9:0] IDX_SYNTH_SRC = 10'h083;
   localparam logic [9:0] IDX_STATUS = 10'h097;

   // slot numbers in the register array
   localparam int S_B_MODE = 0;
   localparam int S_B_HI = 1;
   localparam int S_B_MID = 2;
   localparam int S_B_LO = 3;
   localparam int S_C_MODE = 4;
   localparam int S_C_HI = 5;
   localparam int S_C_MID = 6;
   localparam int S_C_LO = 7;
   localparam int S_SEQ = 8;
   localparam int S_CTRL1 = 9;
   localparam int S_DIV = 10;
   localparam int S_FRATIO = 11;
   localparam int S_SRC = 12;

   localparam logic [9:0] REG_IDX [NREG] = '{
      IDX_B_MODE, IDX_B_FRAC_HI, IDX_B_FRAC_MID, IDX_B_FRAC_LO,
      IDX_C_MODE, IDX_C_FRAC_HI, IDX_C_FRAC_MID, IDX_C_FRAC_LO,
      IDX_SEQ_CTRL, IDX_LOOP_CTRL1, IDX_LOOP_DIV, IDX_LOOP_FRATIO, IDX_SYNTH_SRC};

   // reset values
   localparam logic [15:0] RST_MODE = 16'h0047;
   localparam logic [15:0] RST_B_HI = 16'h001c;
   localparam logic [15:0] RST_B_MID = 16'h0071;
   localparam logic [15:0] RST_B_LO = 16'h00c7;
   localparam logic [15:0] RST_C_HI = 16'h0048;
   // middle fraction byte of synth c has no defined default; zero chosen
   localparam logic [15:0] RST_C_MID = 16'h0000;
   localparam logic [15:0] RST_C_LO = 16'h0097;
   localparam logic [15:0] RST_SEQ = 16'h0003;
   localparam logic [15:0] RST_CTRL1 = 16'h000c;
   localparam logic [15:0] RST_DIV = 16'h0039;
   localparam logic [15:0] RST_FRATIO = 16'h0180;
   localparam logic [15:0] RST_SRC = 16'h0010;

   localparam logic [15:0] REG_RST [NREG] = '{
      RST_MODE, RST_B_HI, RST_B_MID, RST_B_LO, RST_MODE, RST_C_HI, RST_C_MID, RST_C_LO,
      RST_SEQ, RST_CTRL1, RST_DIV, RST_FRATIO, RST_SRC};

   // implemented (stored) bits of each register
   localparam logic [15:0] MSK_MODE = 16'h005f;
   localparam logic [15:0] MSK_BYTE = 16'h00ff;
   localparam logic [15:0] MSK_SEQ = 16'h0003;
   localparam logic [15:0] MSK_CTRL1 = 16'h006f;
   localparam logic [15:0] MSK_DIV = 16'h01fb;
   localparam logic [15:0] MSK_FRATIO = 16'h0187;
   localparam logic [15:0] MSK_SRC = 16'h0012;

   localparam logic [15:0] REG_MSK [NREG] = '{
      MSK_MODE, MSK_BYTE, MSK_BYTE, MSK_BYTE, MSK_MODE, MSK_BYTE, MSK_BYTE, MSK_BYTE,
      MSK_SEQ, MSK_CTRL1, MSK_DIV, MSK_FRATIO, MSK_SRC};

   // field positions
   localparam int F_FRAC_EN = 6;
   localparam int F_INT_HI = 4;
   localparam int F_SEQ_EN = 1;
   localparam int F_SYNTH_SRC = 1;
   localparam int F_REFSEL_HI = 6;
   localparam int F_REFSEL_LO = 5;
   localparam int F_LOOP_FRAC = 2;
   localparam int F_OSC_EN = 1;
   localparam int F_LOOP_EN = 0;
   localparam int F_OUTDIV_HI = 8;
   localparam int F_OUTDIV_LO = 3;
   localparam int F_REFDIV_HI = 1;
   localparam int F_FRATIO_HI = 2;

   typedef enum logic [1:0] {
      REF_MASTER_CLOCK,
      REF_BIT_CLOCK,
      REF_OSCILLATOR,
      REF_RESERVED
   } pfsc_ref_src_t;

   typedef struct packed {
      logic fraction_enable;
      logic [4:0] integer_mult;
      logic [23:0] fraction_mult;
      logic [28:0] effective_mult;
   } pfsc_synth_cfg_t;

   typedef struct packed {
      pfsc_ref_src_t reference_select;
      logic [2:0] reference_divisor;
      logic [6:0] output_divisor;
      logic [4:0] feedback_ratio;
      logic fraction_enable;
      logic oscillator_enable;
      logic enable;
   } pfsc_loop_cfg_t;

endpackage

//--- verilog/pfsc_top.sv
// What this block does
// R1 - synth B integer multiplier, bits 4:0
// R2 - synth C integer multiplier, bits 4:0
// R3 - synth B 24-bit fraction over three bytes
// R4 - synth C 24-bit fraction over three bytes
// R5 - bit 6 selects integer or fractional mode
// R6 - software clears sequencer when master clock used
// R7 - loop reference select: mclk, bclk, oscillator
// R8 - loop bit 2 selects fractional mode
// R9 - loop bit 1 enables oscillator
// R10 - loop bit 0 enables the loop
// R11 - output divider equals code plus one
// R12 - reference pre-divide by 1, 2, 4
// R13 - software keeps divided reference under 13.5MHz
// R14 - feedback ratio 1,2,4,8, top bit 16
// R15 - software picks ratio from reference frequency
// R16 - software keeps reserved bits at one
// R17 - synth reference: oscillator or master clock
// R18 - effective multiplier is integer plus fraction
`timescale 1ns/10ps
module pfsc_top
(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // synthesiser configuration
   output pfsc_pkg::pfsc_synth_cfg_t synth_b,
   output pfsc_pkg::pfsc_synth_cfg_t synth_c,
   output logic synth_sequencer_enable,
   output logic synth_reference_select,
   output pfsc_pkg::pfsc_loop_cfg_t locked_loop
);

   logic [15:0] regs_r [pfsc_pkg::NREG];
   logic [pfsc_pkg::NREG-1:0] hit;
   logic [3:0] hit_idx;
   logic any_hit;
   logic status_hit;
   logic [15:0] status;
   logic [15:0] rd_val;
   logic setup;
   logic wr_access;

   assign setup = psel && !penable;
   assign wr_access = psel && penable && pready && pwrite;

   // address decode
   always_comb
   begin
      any_hit = 1'b0;
      hit_idx = 4'h0;
      rd_val = 16'h0000;
      for (int i = 0; i < pfsc_pkg::NREG; i++)
      begin
         hit[i] = (paddr[11:2] == pfsc_pkg::REG_IDX[i]) && (paddr[1:0] == 2'h0);
         if (hit[i])
         begin
            any_hit = 1'b1;
            hit_idx = 4'(i);
            rd_val = regs_r[i] & pfsc_pkg::REG_MSK[i];
         end
      end
   end

   assign status_hit = (paddr[11:2] == pfsc_pkg::IDX_STATUS) && (paddr[1:0] == 2'h0);

   // reserved codes and sequencer clash, read-only
   assign status = {12'h000,
      regs_r[pfsc_pkg::S_SEQ][pfsc_pkg::F_SEQ_EN] &&
         regs_r[pfsc_pkg::S_SRC][pfsc_pkg::F_SYNTH_SRC],
      regs_r[pfsc_pkg::S_DIV][pfsc_pkg::F_OUTDIV_HI:pfsc_pkg::F_OUTDIV_LO] == 6'h00,
      &regs_r[pfsc_pkg::S_DIV][pfsc_pkg::F_REFDIV_HI:0],
      &regs_r[pfsc_pkg::S_CTRL1][pfsc_pkg::F_REFSEL_HI:pfsc_pkg::F_REFSEL_LO]};

   // one wait-free access phase: ready rises in the cycle after setup
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup && !any_hit && !(status_hit && !pwrite);
         if (setup && !pwrite)
         begin
            prdata <= {16'h0000, status_hit ? status : rd_val};
         end
      end
   end

   // storage; only the implemented bits are kept
   generate
      for (genvar g = 0; g < pfsc_pkg::NREG; g++)
      begin : g_reg
         always_ff @(posedge clock or negedge nrst)
         begin
            if (!nrst)
            begin
               regs_r[g] <= pfsc_pkg::REG_RST[g];
            end
            else if (wr_access && hit[g])
            begin
               regs_r[g] <= pwdata[15:0] & pfsc_pkg::REG_MSK[g];  // [R1] [R2] [R3] [R4]
            end
         end
      end
   endgenerate

   // decode of the phase-locked synthesisers
   function automatic pfsc_pkg::pfsc_synth_cfg_t synth_decode(
      input logic [15:0] mode,
      input logic [15:0] hi,
      input logic [15:0] mid,
      input logic [15:0] lo);
      pfsc_pkg::pfsc_synth_cfg_t c;
      c.fraction_enable = mode[pfsc_pkg::F_FRAC_EN];  // [R5]
      c.integer_mult = mode[pfsc_pkg::F_INT_HI:0];  // [R1] [R2]
      c.fraction_mult = {hi[7:0], mid[7:0], lo[7:0]};  // [R3] [R4]
      // fraction dropped in integer mode
      c.effective_mult = {c.integer_mult,
         c.fraction_enable ? c.fraction_mult : 24'h000000};  // [R18]
      return c;
   endfunction

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         synth_b <= '0;
         synth_c <= '0;
         synth_sequencer_enable <= 1'b0;
         synth_reference_select <= 1'b0;
      end
      else
      begin
         synth_b <= synth_decode(regs_r[pfsc_pkg::S_B_MODE], regs_r[pfsc_pkg::S_B_HI],
            regs_r[pfsc_pkg::S_B_MID], regs_r[pfsc_pkg::S_B_LO]);
         synth_c <= synth_decode(regs_r[pfsc_pkg::S_C_MODE], regs_r[pfsc_pkg::S_C_HI],
            regs_r[pfsc_pkg::S_C_MID], regs_r[pfsc_pkg::S_C_LO]);
         // software must clear this when the master clock is the reference
         synth_sequencer_enable <= regs_r[pfsc_pkg::S_SEQ][pfsc_pkg::F_SEQ_EN];
         synth_reference_select <= regs_r[pfsc_pkg::S_SRC][pfsc_pkg::F_SYNTH_SRC];  // [R17]
      end
   end

   // decode of the frequency-locked loop
   logic [1:0] refdiv_code;
   logic [5:0] outdiv_code;
   logic [2:0] fratio_code;
   logic [2:0] refdiv_val;
   logic [4:0] fratio_val;
   logic loop_bad;

   assign refdiv_code = regs_r[pfsc_pkg::S_DIV][pfsc_pkg::F_REFDIV_HI:0];
   assign outdiv_code = regs_r[pfsc_pkg::S_DIV][pfsc_pkg::F_OUTDIV_HI:pfsc_pkg::F_OUTDIV_LO];
   assign fratio_code = regs_r[pfsc_pkg::S_FRATIO][pfsc_pkg::F_FRATIO_HI:0];
   // a loop left running on a reserved code would lock to nonsense, so hold it off
   assign loop_bad = |status[2:0];

   always_comb
   begin
      unique case (refdiv_code)  // [R12]
         2'h0: refdiv_val = 3'h1;
         2'h1: refdiv_val = 3'h2;
         2'h2: refdiv_val = 3'h4;
         2'h3: refdiv_val = 3'h0;
      endcase
   end

   always_comb
   begin
      if (fratio_code[2])
      begin
         fratio_val = 5'h10;  // [R14]
      end
      else
      begin
         fratio_val = 5'(5'h01 << fratio_code[1:0]);  // [R14]
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         locked_loop <= '0;
      end
      else
      begin
         locked_loop.reference_select <= pfsc_pkg::pfsc_ref_src_t'(
            regs_r[pfsc_pkg::S_CTRL1][pfsc_pkg::F_REFSEL_HI:pfsc_pkg::F_REFSEL_LO]);  // [R7]
         locked_loop.reference_divisor <= refdiv_val;  // [R12]
         // code 0 reads out as 1 and is flagged as reserved
         locked_loop.output_divisor <= {1'b0, outdiv_code} + 7'h01;  // [R11]
         locked_loop.feedback_ratio <= fratio_val;  // [R14]
         locked_loop.fraction_enable <=
            regs_r[pfsc_pkg::S_CTRL1][pfsc_pkg::F_LOOP_FRAC];  // [R8]
         locked_loop.oscillator_enable <=
            regs_r[pfsc_pkg::S_CTRL1][pfsc_pkg::F_OSC_EN];  // [R9]
         locked_loop.enable <=
            regs_r[pfsc_pkg::S_CTRL1][pfsc_pkg::F_LOOP_EN] && !loop_bad;  // [R10]
      end
   end

   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_access;
      psel && penable && pready;
   endsequence

   // outputs hold reset zeros one edge past release, so follow checks wait a cycle
   sequence s_live;
      nrst ##1 1'b1;
   endsequence

   sequence s_read;
      psel && !penable && !pwrite;
   endsequence

   apb_ready_a: assert property (s_setup |=> pready ##1 !pready)
      else $error("access phase not exactly one cycle");
   apb_write_a: assert property ((s_access ##0 (pwrite && any_hit)) |=>  // [R3]
         regs_r[$past(hit_idx)] == ($past(pwdata[15:0]) & pfsc_pkg::REG_MSK[$past(hit_idx)]))
      else $error("write did not land");
   apb_unmapped_a: assert property ((s_setup ##0 (!any_hit && !status_hit)) |=> pslverr)
      else $error("unmapped address not refused");
   int_mode_a: assert property (!synth_b.fraction_enable |->  // [R18]
         synth_b.effective_mult == {synth_b.integer_mult, 24'h000000})
      else $error("fraction not ignored in integer mode");
   frac_mode_a: assert property ($rose(regs_r[pfsc_pkg::S_C_MODE][6]) |=>  // [R5]
         synth_c.fraction_enable && synth_c.effective_mult[23:0] == synth_c.fraction_mult)
      else $error("fractional mode not applied");
   fratio_top_a: assert property (fratio_code[2] ##1 1'b1 |->  // [R14]
         locked_loop.feedback_ratio == 5'h10)
      else $error("feedback ratio not 16");
   outdiv_val_a: assert property (s_live |->  // [R11]
         locked_loop.output_divisor == 7'($past(outdiv_code)) + 7'h01)
      else $error("output divisor wrong");
   refdiv_four_a: assert property ((refdiv_code == 2'h2) |=>  // [R12]
         locked_loop.reference_divisor == 3'h4)
      else $error("reference divisor not 4");
   loop_enable_a: assert property (locked_loop.enable |->  // [R10]
         $past(regs_r[pfsc_pkg::S_CTRL1][0]) && !$past(loop_bad))
      else $error("loop enabled without cause");
   synth_src_a: assert property ($changed(regs_r[pfsc_pkg::S_SRC][1]) |=>  // [R17]
         synth_reference_select == $past(regs_r[pfsc_pkg::S_SRC][1]))
      else $error("synth reference select lags");

   // bus side
   apb_err_pair_a: assert property (pslverr |-> pready)
      else $error("error flag without ready");

   apb_rdata_top_a: assert property (prdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");

   apb_read_a: assert property ((s_read ##0 any_hit) |=>  // [R3] [R4]
         prdata[15:0] == $past(rd_val) && !pslverr)
      else $error("read data not returned");

   apb_status_a: assert property ((s_read ##0 status_hit) |=> prdata[15:0] == $past(status))
      else $error("status not returned");

   // synthesiser outputs trail their registers by one edge
   b_int_mult_a: assert property (s_live |->  // [R1]
         synth_b.integer_mult == $past(regs_r[pfsc_pkg::S_B_MODE][pfsc_pkg::F_INT_HI:0]))
      else $error("synth b integer multiplier wrong");

   c_int_mult_a: assert property (s_live |->  // [R2]
         synth_c.integer_mult == $past(regs_r[pfsc_pkg::S_C_MODE][pfsc_pkg::F_INT_HI:0]))
      else $error("synth c integer multiplier wrong");

   b_frac_mult_a: assert property (s_live |->  // [R3]
         synth_b.fraction_mult == {$past(regs_r[pfsc_pkg::S_B_HI][7:0]),
         $past(regs_r[pfsc_pkg::S_B_MID][7:0]), $past(regs_r[pfsc_pkg::S_B_LO][7:0])})
      else $error("synth b fraction wrong");

   c_frac_mult_a: assert property (s_live |->  // [R4]
         synth_c.fraction_mult == {$past(regs_r[pfsc_pkg::S_C_HI][7:0]),
         $past(regs_r[pfsc_pkg::S_C_MID][7:0]), $past(regs_r[pfsc_pkg::S_C_LO][7:0])})
      else $error("synth c fraction wrong");

   b_mode_a: assert property (s_live |->  // [R5]
         synth_b.fraction_enable == $past(regs_r[pfsc_pkg::S_B_MODE][pfsc_pkg::F_FRAC_EN]))
      else $error("synth b mode wrong");

   c_mode_a: assert property (s_live |->  // [R5]
         synth_c.fraction_enable == $past(regs_r[pfsc_pkg::S_C_MODE][pfsc_pkg::F_FRAC_EN]))
      else $error("synth c mode wrong");

   b_frac_sum_a: assert property (synth_b.fraction_enable |->  // [R18]
         synth_b.effective_mult == {synth_b.integer_mult, synth_b.fraction_mult})
      else $error("synth b fraction not applied");

   c_frac_sum_a: assert property (synth_c.fraction_enable |->  // [R18]
         synth_c.effective_mult == {synth_c.integer_mult, synth_c.fraction_mult})
      else $error("synth c fraction not applied");

   c_int_mode_a: assert property (!synth_c.fraction_enable |->  // [R18]
         synth_c.effective_mult == {synth_c.integer_mult, 24'h000000})
      else $error("synth c fraction not ignored");

   // frequency-locked loop fields
   loop_ref_a: assert property (s_live |->  // [R7]
         locked_loop.reference_select ==
         $past(regs_r[pfsc_pkg::S_CTRL1][pfsc_pkg::F_REFSEL_HI:pfsc_pkg::F_REFSEL_LO]))
      else $error("loop reference select wrong");

   loop_frac_a: assert property (s_live |->  // [R8]
         locked_loop.fraction_enable == $past(regs_r[pfsc_pkg::S_CTRL1][pfsc_pkg::F_LOOP_FRAC]))
      else $error("loop mode wrong");

   loop_osc_a: assert property (s_live |->  // [R9]
         locked_loop.oscillator_enable == $past(regs_r[pfsc_pkg::S_CTRL1][pfsc_pkg::F_OSC_EN]))
      else $error("loop oscillator enable wrong");

   loop_resv_off_a: assert property ($past(loop_bad) |-> !locked_loop.enable)  // [R10]
      else $error("loop left on with a reserved code");

   loop_on_a: assert property ((s_live ##0
         $past(regs_r[pfsc_pkg::S_CTRL1][pfsc_pkg::F_LOOP_EN] && !loop_bad)) |->  // [R10]
         locked_loop.enable)
      else $error("loop not enabled");

   outdiv_range_a: assert property (s_live |->  // [R11]
         locked_loop.output_divisor != 7'h00 && locked_loop.output_divisor <= 7'h40)
      else $error("output divisor out of range");

   refdiv_one_a: assert property ((nrst && refdiv_code == 2'h0) |=>  // [R12]
         locked_loop.reference_divisor == 3'h1)
      else $error("reference divisor not 1");

   refdiv_two_a: assert property ((nrst && refdiv_code == 2'h1) |=>  // [R12]
         locked_loop.reference_divisor == 3'h2)
      else $error("reference divisor not 2");

   refdiv_resv_a: assert property ((nrst && refdiv_code == 2'h3) |=>  // [R12]
         locked_loop.reference_divisor == 3'h0)
      else $error("reserved reference divisor not 0");

   fratio_one_a: assert property ((nrst && fratio_code == 3'h0) |=>  // [R14]
         locked_loop.feedback_ratio == 5'h01)
      else $error("feedback ratio not 1");

   fratio_eight_a: assert property ((nrst && fratio_code == 3'h3) |=>  // [R14]
         locked_loop.feedback_ratio == 5'h08)
      else $error("feedback ratio not 8");

endmodule

//--- tb/pfsc_top_test.sv
`timescale 1ns/10ps
module pfsc_top_test;
   logic clock;
   logic nrst;
   logic psel;
   logic penable;
   logic pwrite;
   logic pready;
   logic pslverr;
   logic e;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [31:0] q;
   logic [9:0] base;
   logic [5:0] oc;
   pfsc_pkg::pfsc_synth_cfg_t synth_b;
   pfsc_pkg::pfsc_synth_cfg_t synth_c;
   pfsc_pkg::pfsc_synth_cfg_t sy;
   pfsc_pkg::pfsc_loop_cfg_t locked_loop;
   logic synth_sequencer_enable;
   logic synth_reference_select;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;
   logic [15:0] rst_tab [13] = '{16'h0047, 16'h001c, 16'h0071, 16'h00c7, 16'h0047, 16'h0048,
      16'h0000, 16'h0097, 16'h0003, 16'h000c, 16'h0039, 16'h0180, 16'h0010};
   logic [5:0] oc_tab [4] = '{6'h01, 6'h02, 6'h3f, 6'h00};
   logic [2:0] rdv_tab [4] = '{3'h1, 3'h2, 3'h4, 3'h0};

   pfsc_top dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .synth_b(synth_b), .synth_c(synth_c),
      .synth_sequencer_enable(synth_sequencer_enable),
      .synth_reference_select(synth_reference_select), .locked_loop(locked_loop));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // whole run needs well under a thousand cycles
   always @(posedge clock)
   begin
      cycles++;
      if (cycles > 3000)
      begin
         n_mismatch++;
         tally_and_finish;
      end
   end

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // request held until pready is seen high at a rising edge
   task apb(input logic w, input logic [9:0] idx, input logic [15:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {16'h0000, d};
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
         @(posedge clock);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [9:0] idx, input logic [15:0] d);
      apb(1'b1, idx, d);
      chk($sformatf("write error %h", idx), 32'h0, {31'h0, e});
   endtask

   task rd(input logic [9:0] idx, input logic [15:0] exp);
      apb(1'b0, idx, 16'h0000);
      chk($sformatf("read %h", idx), {16'h0000, exp}, q);
   endtask

   // outputs trail the register by one edge
   task settle;
      repeat (2) @(negedge clock);
   endtask

   initial
   begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      settle;
      for (int i = 0; i < 13; i++)
         rd(pfsc_pkg::REG_IDX[i], rst_tab[i]);
      chk("b mult", {3'h0, 5'd7, 24'h1c71c7}, {3'h0, synth_b.effective_mult});
      chk("c int", 32'h7, {27'h0, synth_c.integer_mult});
      chk("loop reset", {14'h0, 3'd2, 7'd8, 5'd1, 3'b100}, {14'h0, locked_loop.reference_divisor,
         locked_loop.output_divisor, locked_loop.feedback_ratio, locked_loop.fraction_enable,
         locked_loop.oscillator_enable, locked_loop.enable});
      $display("test reset values done");
      for (int s = 0; s < 2; s++)
      begin
         base = (s == 1) ? pfsc_pkg::IDX_C_MODE : pfsc_pkg::IDX_B_MODE;
         wr(base, 16'h005f);
         wr(base + 10'h1, 16'h00ab);
         wr(base + 10'h2, 16'h00cd);
         wr(base + 10'h3, 16'h00ef);
         rd(base + 10'h2, 16'h00cd);
         settle;
         sy = (s == 1) ? synth_c : synth_b;
         chk("frac mult", {3'h0, 5'd31, 24'habcdef}, {3'h0, sy.effective_mult});
         wr(base, 16'h0001);
         settle;
         sy = (s == 1) ? synth_c : synth_b;
         chk("int mult", {3'h0, 5'd1, 24'h0}, {3'h0, sy.effective_mult});
         chk("fraction", 32'habcdef, {8'h0, sy.fraction_mult});
         wr(base, 16'h0047);
         settle;
         sy = (s == 1) ? synth_c : synth_b;
         chk("mode back", {3'h0, 5'd7, 24'habcdef}, {3'h0, sy.effective_mult});
      end
      $display("test synthesiser multipliers done");
      wr(pfsc_pkg::IDX_SEQ_CTRL, 16'h0001);
      settle;
      chk("sequencer", 32'h0, {31'h0, synth_sequencer_enable});
      for (int c = 0; c < 4; c++)
      begin
         wr(pfsc_pkg::IDX_LOOP_CTRL1, 16'(c * 32) | 16'h000f);
         settle;
         chk("loop ref", c, {30'h0, locked_loop.reference_select});
         chk("loop bits", {29'h0, 2'b11, c != 3}, {29'h0, locked_loop.fraction_enable,
            locked_loop.oscillator_enable, locked_loop.enable});
      end
      wr(pfsc_pkg::IDX_LOOP_CTRL1, 16'h0008);
      settle;
      chk("loop off", 32'h0, {29'h0, locked_loop.fraction_enable,
         locked_loop.oscillator_enable, locked_loop.enable});
      wr(pfsc_pkg::IDX_LOOP_CTRL1, 16'h000d);
      for (int i = 0; i < 4; i++)
      begin
         oc = oc_tab[i];
         wr(pfsc_pkg::IDX_LOOP_DIV, {7'h00, oc, 1'b0, 2'(i)});
         settle;
         chk("ref div", {29'h0, rdv_tab[i]}, {29'h0, locked_loop.reference_divisor});
         if (oc != 6'h00)
            chk("out div", {25'h0, 1'b0, oc} + 32'h1, {25'h0, locked_loop.output_divisor});
         chk("gated en", {31'h0, i < 3}, {31'h0, locked_loop.enable});
      end
      rd(pfsc_pkg::IDX_STATUS, 16'h0006);
      wr(pfsc_pkg::IDX_LOOP_DIV, 16'h0039);
      for (int c = 0; c < 8; c++)
      begin
         wr(pfsc_pkg::IDX_LOOP_FRATIO, 16'h0180 | 16'(c));
         settle;
         chk("ratio", (c < 4) ? (1 << c) : 16, {27'h0, locked_loop.feedback_ratio});
      end
      $display("test loop fields done");
      wr(pfsc_pkg::IDX_SYNTH_SRC, 16'h0012);
      settle;
      chk("synth ref", 32'h1, {31'h0, synth_reference_select});
      rd(pfsc_pkg::IDX_SYNTH_SRC, 16'h0012);
      wr(pfsc_pkg::IDX_SYNTH_SRC, 16'h0010);
      settle;
      chk("synth ref", 32'h0, {31'h0, synth_reference_select});
      apb(1'b0, 10'h090, 16'h0000);
      chk("unmapped read", 32'h1, {31'h0, e});
      apb(1'b1, 10'h3ff, 16'hffff);
      chk("unmapped write", 32'h1, {31'h0, e});
      apb(1'b1, pfsc_pkg::IDX_STATUS, 16'hffff);
      chk("status write", 32'h1, {31'h0, e});
      rd(pfsc_pkg::IDX_LOOP_FRATIO, 16'h0187);
      $display("test refused accesses done");
      tally_and_finish;
   end
endmodule
